// ### rtl/olmr_bank.sv
// Top of the output mixer routing register bank.
// Holds twenty mixing registers and three driver level registers, answers
// control port reads one cycle later, and tells the analog stage which
// driver gains changed. Assumes the control port and the analog
// stage's applied pulses are synchronous to core_clk.
module olmr_bank (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [3:0] gain_applied,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    output logic reg_addr_miss,
    output olmr_pkg::olmr_mix_t mix_path [olmr_pkg::OLMR_NUM_MIX],
    output olmr_pkg::olmr_drv_t hp_right_main,
    output olmr_pkg::olmr_drv_t hp_right_com,
    output olmr_pkg::olmr_drv_t mono_line_out,
    output logic left_line_out_pending,
    output logic [3:0] gain_update,
    output logic level_code_reserved
);

    // ------------------------------------------------------------------
    // request bundle
    // ------------------------------------------------------------------
    olmr_pkg::olmr_req_t req;

    // one bundle feeds every register so the decode is identical
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;
    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;

    // ------------------------------------------------------------------
    // internal nets
    // ------------------------------------------------------------------
    logic [olmr_pkg::OLMR_NUM_MIX-1:0] mix_chg;
    logic [olmr_pkg::OLMR_NUM_DRV-1:0] drv_mix_chg;
    logic [olmr_pkg::OLMR_NUM_LVL-1:0] lvl_chg;
    logic [olmr_pkg::OLMR_NUM_DRV-1:0] next_gain_update;
    logic [7:0] lvl_value [olmr_pkg::OLMR_NUM_LVL];
    logic [7:0] next_rdata;
    logic next_miss;
    logic lvl_hit;
    logic next_reserved;
    logic next_left_pending;

    // ------------------------------------------------------------------
    // mixing registers
    // ------------------------------------------------------------------
    // one instance per source-to-output path; the address table orders
    // them right main (59..64), right common (66..71), mono (73..78) and
    // then left line output (80, 81)
    generate
        for (genvar i = 0; i < olmr_pkg::OLMR_NUM_MIX; i++) begin : g_mix
            olmr_mix_reg #(
                .ADDR(olmr_pkg::OLMR_MIX_ADDR[i])
            ) u_mix (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .req(req),
                .path(mix_path[i]),
                .changed(mix_chg[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // gather mix changes per driver
    // ------------------------------------------------------------------
    // a change in any path that feeds a driver disturbs that driver's gain
    generate
        for (genvar d = 0; d < olmr_pkg::OLMR_NUM_DRV; d++) begin : g_drv
            assign drv_mix_chg[d] =
                |(mix_chg & olmr_pkg::OLMR_DRV_MIX_MASK[d]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // driver level registers
    // ------------------------------------------------------------------
    // right main headphone: high-z select and power bit are writable
    olmr_level_reg #(
        .ADDR(olmr_pkg::OLMR_HP_RIGHT_MAIN_LEVEL_CTRL),
        .WMASK(olmr_pkg::OLMR_HP_LVL_WMASK),
        .RST(olmr_pkg::OLMR_HP_LVL_RST)
    ) u_lvl_hp_main (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .req(req),
        .mix_changed(drv_mix_chg[olmr_pkg::OLMR_DRV_HP_RIGHT_MAIN]),
        .applied(gain_applied[olmr_pkg::OLMR_DRV_HP_RIGHT_MAIN]),
        .drv(hp_right_main),
        .value(lvl_value[0]),
        .changed(lvl_chg[0])
    );

    // right common headphone: same layout as the main driver
    olmr_level_reg #(
        .ADDR(olmr_pkg::OLMR_HP_RIGHT_COM_LEVEL_CTRL),
        .WMASK(olmr_pkg::OLMR_HP_LVL_WMASK),
        .RST(olmr_pkg::OLMR_HP_LVL_RST)
    ) u_lvl_hp_com (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .req(req),
        .mix_changed(drv_mix_chg[olmr_pkg::OLMR_DRV_HP_RIGHT_COM]),
        .applied(gain_applied[olmr_pkg::OLMR_DRV_HP_RIGHT_COM]),
        .drv(hp_right_com),
        .value(lvl_value[1]),
        .changed(lvl_chg[1])
    );

    // mono line output: bit 2 is masked out of the write, so it stays
    // at its reset zero whatever software sends
    olmr_level_reg #(
        .ADDR(olmr_pkg::OLMR_MONO_OUT_LEVEL_CTRL),
        .WMASK(olmr_pkg::OLMR_MONO_LVL_WMASK),
        .RST(olmr_pkg::OLMR_MONO_LVL_RST)
    ) u_lvl_mono (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .req(req),
        .mix_changed(drv_mix_chg[olmr_pkg::OLMR_DRV_MONO_LINE_OUT]),
        .applied(gain_applied[olmr_pkg::OLMR_DRV_MONO_LINE_OUT]),
        .drv(mono_line_out),
        .value(lvl_value[2]),
        .changed(lvl_chg[2])
    );

    // ------------------------------------------------------------------
    // left line output pending
    // ------------------------------------------------------------------
    // its level register lives elsewhere, so the pending state for its
    // two paths held here is exported for that register to merge
    always_comb begin
        next_left_pending = left_line_out_pending;
        if (drv_mix_chg[olmr_pkg::OLMR_DRV_LEFT_LINE_OUT]) begin
            next_left_pending = 1'b1;
        end else if (gain_applied[olmr_pkg::OLMR_DRV_LEFT_LINE_OUT]) begin
            next_left_pending = 1'b0;
        end
    end

    // resets pending, matching the status bit of the other drivers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_line_out_pending <= 1'b1;
        end else begin
            left_line_out_pending <= next_left_pending;
        end
    end

    // ------------------------------------------------------------------
    // change strobes to the analog stage
    // ------------------------------------------------------------------
    // one pulse per driver, the cycle after the write that changed it;
    // the analog stage answers on gain_applied once it has ramped
    always_comb begin
        next_gain_update = drv_mix_chg;
        next_gain_update[olmr_pkg::OLMR_DRV_HP_RIGHT_MAIN] =
            drv_mix_chg[olmr_pkg::OLMR_DRV_HP_RIGHT_MAIN] | lvl_chg[0];
        next_gain_update[olmr_pkg::OLMR_DRV_HP_RIGHT_COM] =
            drv_mix_chg[olmr_pkg::OLMR_DRV_HP_RIGHT_COM] | lvl_chg[1];
        next_gain_update[olmr_pkg::OLMR_DRV_MONO_LINE_OUT] =
            drv_mix_chg[olmr_pkg::OLMR_DRV_MONO_LINE_OUT] | lvl_chg[2];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_update <= '0;
        end else begin
            gain_update <= next_gain_update;
        end
    end

    // ------------------------------------------------------------------
    // reserved level code watch
    // ------------------------------------------------------------------
    // the code is still stored as written; this pulse only lets the
    // system notice software that breaks the level code limit
    always_comb begin
        lvl_hit = (reg_addr == olmr_pkg::OLMR_HP_RIGHT_MAIN_LEVEL_CTRL) ||
                  (reg_addr == olmr_pkg::OLMR_HP_RIGHT_COM_LEVEL_CTRL) ||
                  (reg_addr == olmr_pkg::OLMR_MONO_OUT_LEVEL_CTRL);
        next_reserved = reg_wr && lvl_hit &&
            (reg_wdata[olmr_pkg::OLMR_LEVEL_MSB:olmr_pkg::OLMR_LEVEL_LSB] >
             olmr_pkg::OLMR_LEVEL_MAX);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_code_reserved <= 1'b0;
        end else begin
            level_code_reserved <= next_reserved;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // offsets outside the bank read as zero and raise the miss flag, so
    // a wrong page or address is visible without stalling the port
    always_comb begin
        next_rdata = olmr_pkg::OLMR_UNMAPPED_READ;
        next_miss = 1'b1;
        for (int i = 0; i < olmr_pkg::OLMR_NUM_MIX; i++) begin
            if (reg_addr == olmr_pkg::OLMR_MIX_ADDR[i]) begin
                next_rdata = mix_path[i];
                next_miss = 1'b0;
            end
        end
        if (reg_addr == olmr_pkg::OLMR_HP_RIGHT_MAIN_LEVEL_CTRL) begin
            next_rdata = lvl_value[0];
            next_miss = 1'b0;
        end
        if (reg_addr == olmr_pkg::OLMR_HP_RIGHT_COM_LEVEL_CTRL) begin
            next_rdata = lvl_value[1];
            next_miss = 1'b0;
        end
        if (reg_addr == olmr_pkg::OLMR_MONO_OUT_LEVEL_CTRL) begin
            next_rdata = lvl_value[2];
            next_miss = 1'b0;
        end
    end

    // read data is captured on the request edge and shows the value from
    // before any write in that same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= olmr_pkg::OLMR_UNMAPPED_READ;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // valid marks the single answer cycle of each read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_rd;
        end
    end

    // miss qualifies a read answer or a write to an unmapped offset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_addr_miss <= 1'b0;
        end else begin
            reg_addr_miss <= (reg_rd || reg_wr) && next_miss;
        end
    end

endmodule

// ### rtl/olmr_pkg.sv
// Package for the output mixer routing register bank: addresses, field
// positions, reset values, driver numbering and the carrier structs.
// Assumes one 25 MHz core clock and an 8-bit control port that is already
// synchronous to it.
//
// What this block does
// - routing bit 7 of each mix register connects its source when one.
// - every routing bit resets to zero, so nothing is connected.
// - bits 6..0 hold a read/write attenuation code, reset all zeros.
// - registers 62..64 feed the right main headphone driver.
// - registers 66..71 feed the right common headphone driver in order.
// - registers 73..78 feed the mono line output in the same order.
// - registers 80 and 81 feed the left line output.
// - level field bits 7..4 select 0 to 9 dB, reset 0000.
// - bit 3 unmutes the driver when one, resets muted.
// - headphone bit 2 picks weak common mode or high-z, resets one.
// - bit 1 reads one while programmed gains are pending, resets one.
// - headphone bit 0 powers the driver fully up, resets zero.
// - mono level bit 2 is read-only reserved; software writes zero.
// - mono level bit 0 is a read/write power bit, resets zero.
// - registers 59..61 also feed the right main headphone driver.

package olmr_pkg;

    // ------------------------------------------------------------------
    // bank geometry
    // ------------------------------------------------------------------
    localparam int OLMR_NUM_MIX = 20;
    localparam int OLMR_NUM_LVL = 3;
    localparam int OLMR_NUM_DRV = 4;

    // driver numbering
    localparam int OLMR_DRV_HP_RIGHT_MAIN = 0;
    localparam int OLMR_DRV_HP_RIGHT_COM = 1;
    localparam int OLMR_DRV_MONO_LINE_OUT = 2;
    localparam int OLMR_DRV_LEFT_LINE_OUT = 3;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OLMR_MIX_ADDR [OLMR_NUM_MIX] = '{
        8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40,
        8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
        8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E,
        8'h50, 8'h51};
    localparam logic [7:0] OLMR_HP_RIGHT_MAIN_LEVEL_CTRL = 8'h41;
    localparam logic [7:0] OLMR_HP_RIGHT_COM_LEVEL_CTRL = 8'h48;
    localparam logic [7:0] OLMR_MONO_OUT_LEVEL_CTRL = 8'h4F;

    // which mix registers feed which driver, bit i is mix register i
    localparam logic [OLMR_NUM_MIX-1:0] OLMR_DRV_MIX_MASK [OLMR_NUM_DRV] =
        '{20'h0003F, 20'h00FC0, 20'h3F000, 20'hC0000};

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int OLMR_LEVEL_MSB = 7;
    localparam int OLMR_LEVEL_LSB = 4;
    localparam int OLMR_UNMUTE_BIT = 3;
    localparam int OLMR_HIZ_BIT = 2;
    localparam int OLMR_STAT_BIT = 1;
    localparam int OLMR_POWER_BIT = 0;
    localparam logic [3:0] OLMR_LEVEL_MAX = 4'h9;
    localparam logic [7:0] OLMR_MIX_RST = 8'h00;
    localparam logic [7:0] OLMR_HP_LVL_RST = 8'h06;
    localparam logic [7:0] OLMR_MONO_LVL_RST = 8'h02;
    localparam logic [7:0] OLMR_HP_LVL_WMASK = 8'hFD;
    localparam logic [7:0] OLMR_MONO_LVL_WMASK = 8'hF9;
    localparam logic [7:0] OLMR_UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } olmr_req_t;

    typedef struct packed {
        logic route;
        logic [6:0] atten;
    } olmr_mix_t;

    typedef struct packed {
        logic [3:0] level;
        logic unmute;
        logic hiz_pd;
        logic pending;
        logic power;
    } olmr_drv_t;

endpackage

// ### rtl/olmr_mix_reg.sv
// One source-to-output mixing register: route bit and attenuation code.
// Assumes the control request is synchronous to core_clk.
module olmr_mix_reg #(
    parameter logic [7:0] ADDR = 8'h00
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire olmr_pkg::olmr_req_t req,
    output olmr_pkg::olmr_mix_t path,
    output logic changed
);

    logic hit;

    assign hit = req.wr && (req.addr == ADDR);

    // ------------------------------------------------------------------
    // storage: whole byte is read/write
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            path <= olmr_pkg::OLMR_MIX_RST;
        end else if (hit) begin
            path <= req.wdata;
        end
    end

    // a rewrite of the same value does not disturb the analog stage
    assign changed = hit && (req.wdata != path);

endmodule

// ### rtl/olmr_level_reg.sv
// One driver level control register with its gain-pending status bit.
// Assumes the analog stage pulses applied once a new setting has settled.
module olmr_level_reg #(
    parameter logic [7:0] ADDR = 8'h00,
    parameter logic [7:0] WMASK = 8'h00,
    parameter logic [7:0] RST = 8'h00
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire olmr_pkg::olmr_req_t req,
    input wire logic mix_changed,
    input wire logic applied,
    output olmr_pkg::olmr_drv_t drv,
    output logic [7:0] value,
    output logic changed
);

    logic hit;
    logic [7:0] ctl;
    logic pending;

    assign hit = req.wr && (req.addr == ADDR);

    // ------------------------------------------------------------------
    // writable bits; masked bits keep their reset value
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= RST;
        end else if (hit) begin
            ctl <= (req.wdata & WMASK) | (ctl & ~WMASK);
        end
    end

    // level field change counts; mute and power are not gains
    assign changed = hit && (req.wdata[olmr_pkg::OLMR_LEVEL_MSB:
        olmr_pkg::OLMR_LEVEL_LSB] != drv.level);

    // ------------------------------------------------------------------
    // pending status: a new change wins over a same-cycle applied pulse
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= RST[olmr_pkg::OLMR_STAT_BIT];
        end else if (changed || mix_changed) begin
            pending <= 1'b1;
        end else if (applied) begin
            pending <= 1'b0;
        end
    end

    assign drv.level = ctl[olmr_pkg::OLMR_LEVEL_MSB:olmr_pkg::OLMR_LEVEL_LSB];
    assign drv.unmute = ctl[olmr_pkg::OLMR_UNMUTE_BIT];
    assign drv.hiz_pd = ctl[olmr_pkg::OLMR_HIZ_BIT];
    assign drv.pending = pending;
    assign drv.power = ctl[olmr_pkg::OLMR_POWER_BIT];

    // readback merges the hardware status into its bit
    always_comb begin
        value = ctl;
        value[olmr_pkg::OLMR_STAT_BIT] = pending;
    end

endmodule

// ### testbench/olmr_bank_chk.sv
// Concurrent checks on the ports of the output mixer routing bank.
// Assumes one core clock and is bound to olmr_bank below.
module olmr_bank_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [3:0] gain_applied,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic reg_addr_miss,
    input wire olmr_pkg::olmr_mix_t mix_path [olmr_pkg::OLMR_NUM_MIX],
    input wire olmr_pkg::olmr_drv_t hp_right_main,
    input wire olmr_pkg::olmr_drv_t hp_right_com,
    input wire olmr_pkg::olmr_drv_t mono_line_out,
    input wire logic left_line_out_pending,
    input wire logic [3:0] gain_update,
    input wire logic level_code_reserved
);
    // ------------------------------------------------------------------
    // port properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // request steps, named so the answers read as sequences
    sequence miss_rd_s;
        reg_rd && (reg_addr < 8'h3B || reg_addr > 8'h51);
    endsequence
    sequence com_rd_s;
        reg_rd && reg_addr == 8'h48;
    endsequence
    sequence main_wr_s;
        reg_wr && reg_addr == 8'h41;
    endsequence

    rd_valid_a: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read answer missing");
    rd_quiet_a: assert property (!reg_rd |=> !reg_rdata_valid)
        else $error("read answer without request");
    miss_read_a: assert property (miss_rd_s |=> reg_addr_miss &&
        reg_rdata == 8'h00)
        else $error("unmapped read not refused");
    // every mix register takes the written byte whole
    for (genvar i = 0; i < olmr_pkg::OLMR_NUM_MIX; i++) begin : g_mix
        mix_write_a: assert property (
            reg_wr && reg_addr == olmr_pkg::OLMR_MIX_ADDR[i] |=>
            mix_path[i] == $past(reg_wdata))
            else $error("mix register write lost");
    end
    main_level_a: assert property (
        main_wr_s |=> hp_right_main.level == $past(reg_wdata[7:4])
        && hp_right_main.unmute == $past(reg_wdata[3])
        && hp_right_main.hiz_pd == $past(reg_wdata[2])
        && hp_right_main.power == $past(reg_wdata[0]))
        else $error("main level fields wrong");
    mono_field_a: assert property (
        reg_wr && reg_addr == 8'h4F |=> !mono_line_out.hiz_pd
        && mono_line_out.power == $past(reg_wdata[0]))
        else $error("mono level fields wrong");
    code_flag_a: assert property (
        reg_wr && reg_wdata[7:4] > 4'h9 &&
        (reg_addr == 8'h41 || reg_addr == 8'h48 || reg_addr == 8'h4F)
        |=> level_code_reserved)
        else $error("reserved level code not flagged");
    pend_mark_a: assert property (
        gain_update[1] |-> hp_right_com.pending)
        else $error("update without pending");
    pend_clear_a: assert property (
        $fell(hp_right_com.pending) |-> $past(gain_applied[1]))
        else $error("pending cleared without applied");
    com_read_a: assert property (
        com_rd_s |=> reg_rdata == $past(hp_right_com))
        else $error("level readback wrong");
endmodule

bind olmr_bank olmr_bank_chk u_olmr_bank_chk (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .gain_applied(gain_applied),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .reg_addr_miss(reg_addr_miss), .mix_path(mix_path),
    .hp_right_main(hp_right_main), .hp_right_com(hp_right_com),
    .mono_line_out(mono_line_out),
    .left_line_out_pending(left_line_out_pending),
    .gain_update(gain_update), .level_code_reserved(level_code_reserved));

// ### testbench/tb_top.sv
// Self-checking bench for the output mixer routing register bank.
// Assumes a one-cycle register port that never stalls; inputs
// change at the falling edge, outputs are sampled 1 ns after rising.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // signals and helpers
    // ------------------------------------------------------------------
    logic core_clk, rst_n, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] gain_applied, gain_update;
    logic reg_rdata_valid, reg_addr_miss, left_line_out_pending;
    logic level_code_reserved;
    olmr_pkg::olmr_mix_t mix_path [olmr_pkg::OLMR_NUM_MIX];
    olmr_pkg::olmr_drv_t hp_right_main, hp_right_com, mono_line_out;
    logic [3:0] pend;
    logic [7:0] one_hot;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;

    olmr_bank u_olmr_bank (
        .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .gain_applied(gain_applied), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .reg_addr_miss(reg_addr_miss),
        .mix_path(mix_path), .hp_right_main(hp_right_main),
        .hp_right_com(hp_right_com), .mono_line_out(mono_line_out),
        .left_line_out_pending(left_line_out_pending),
        .gain_update(gain_update), .level_code_reserved(level_code_reserved));

    // pending bits of all four drivers, main headphone in bit 0
    assign pend = {left_line_out_pending, mono_line_out.pending,
                   hp_right_com.pending, hp_right_main.pending};

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hang costs a mismatch; the tests need well under 600 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 2000) begin
            fail_count++;
            $display("[FAIL] %0t run timed out", $time);
            complete_run();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one request per cycle; calls chain back to back with no gap
    task automatic access(input logic w, input logic r,
                          input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        access(1'b0, 1'b1, a, 8'h00);
        check(reg_rdata_valid, 8'h01, "read valid");
        check(reg_rdata, exp, "read data");
    endtask

    task automatic idle();
        access(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    // analog stage reports every driver in the mask as settled
    task automatic apply(input logic [3:0] m);
        @(negedge core_clk);
        gain_applied = m;
        @(negedge core_clk);
        gain_applied = 4'h0;
    endtask

    function automatic logic [7:0] pat(input int i);
        return (i % 2 == 1) ? (8'h80 | 8'(i)) : (8'h70 - 8'(i));
    endfunction

    // registers 59..64 main, 66..71 common, 73..78 mono, 80..81 left
    function automatic int drv_of(input int i);
        if (i < 6) return 0;
        if (i < 12) return 1;
        if (i < 18) return 2;
        return 3;
    endfunction

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        gain_applied = 4'h0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        for (int i = 0; i < olmr_pkg::OLMR_NUM_MIX; i++) begin
            rd(olmr_pkg::OLMR_MIX_ADDR[i], 8'h00);
        end
        rd(8'h41, 8'h06);
        rd(8'h48, 8'h06);
        rd(8'h4F, 8'h02);
        check(left_line_out_pending, 8'h01, "left pending");
        $display("test reset values done");
        for (int i = 0; i < olmr_pkg::OLMR_NUM_MIX; i++) begin
            wr(olmr_pkg::OLMR_MIX_ADDR[i], pat(i));
        end
        for (int i = 0; i < olmr_pkg::OLMR_NUM_MIX; i++) begin
            rd(olmr_pkg::OLMR_MIX_ADDR[i], pat(i));
            check(mix_path[i], pat(i), "mix path");
        end
        $display("test mix readback done");
        // each path marks only the driver it feeds
        for (int i = 0; i < olmr_pkg::OLMR_NUM_MIX; i++) begin
            apply(4'hF);
            one_hot = 8'(1 << drv_of(i));
            wr(olmr_pkg::OLMR_MIX_ADDR[i], ~pat(i));
            check(gain_update, one_hot, "update");
            idle();
            check(pend, one_hot, "map");
        end
        $display("test path mapping done");
        // every level code, reserved ones flagged but stored
        for (int c = 0; c < 16; c++) begin
            wr(8'h41, {4'(c), 4'h0});
            check(level_code_reserved, 8'(c > 9), "code flag");
            check(hp_right_main.level, 8'(c), "level");
        end
        wr(8'h41, 8'h95);
        idle();
        check(hp_right_main, 8'h97, "main fields");
        wr(8'h41, 8'h01);
        idle();
        check(hp_right_main, 8'h03, "main drive");
        $display("test main level done");
        apply(4'hF);
        wr(8'h48, 8'h0C);
        idle();
        check(hp_right_com, 8'h0C, "unmute only");
        wr(8'h48, 8'h9E);
        check(gain_update, 8'h02, "com update");
        rd(8'h48, 8'h9E);
        apply(4'h2);
        rd(8'h48, 8'h9C);
        wr(8'h48, 8'h9E);
        rd(8'h48, 8'h9C);
        $display("test com pending done");
        wr(8'h4F, 8'hFF);
        check(level_code_reserved, 8'h01, "mono code");
        rd(8'h4F, 8'hFB);
        wr(8'h4F, 8'h91);
        check(level_code_reserved, 8'h00, "mono code ok");
        rd(8'h4F, 8'h93);
        // read and write in one cycle: the read returns the old byte
        access(1'b1, 1'b1, 8'h4F, 8'h01);
        check(reg_rdata, 8'h93, "read before write");
        rd(8'h4F, 8'h03);
        $display("test mono level done");
        rd(8'h3A, 8'h00);
        check(reg_addr_miss, 8'h01, "miss low");
        rd(8'h52, 8'h00);
        check(reg_addr_miss, 8'h01, "miss high");
        wr(8'h3A, 8'hFF);
        check(reg_addr_miss, 8'h01, "miss write");
        rd(8'h3B, ~pat(0));
        check(reg_addr_miss, 8'h00, "hit");
        idle();
        $display("test unmapped done");
        complete_run();
    end
endmodule
